// ==== simd_datapath.sv ====
// Top of the packed integer datapath: issue handshake, byte shifts, result register
// Assumes the issue stage holds all inputs stable while issue_ready_o is low
`timescale 1ns/100ps
`default_nettype none
module simd_datapath #(
  parameter int STORE_DEPTH = 4
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic issue_valid_i,
  output logic issue_ready_o,
  input wire simd_pkg::op_t op_i,
  input wire logic wide_i,
  input wire logic [simd_pkg::DATA_W-1:0] dst_i,
  input wire logic [simd_pkg::DATA_W-1:0] src_i,
  input wire logic src_is_mem_i,
  input wire logic [simd_pkg::ADDR_W-1:0] mem_addr_i,
  input wire logic [simd_pkg::IMM_W-1:0] imm_i,
  input wire logic store_valid_i,
  input wire logic [simd_pkg::ADDR_W-1:0] store_addr_i,
  input wire logic [simd_pkg::SIZE_W-1:0] store_bytes_i,
  output logic store_ready_o,
  input wire logic store_drain_i,
  output logic result_valid_o,
  output logic [simd_pkg::DATA_W-1:0] result_o,
  output logic fault_o
);
  import simd_pkg::*;
  typedef struct packed {
    logic valid;
    logic fault;
    logic wide;
    op_t op;
    logic [IMM_W-1:0] imm;
    logic [DATA_W-1:0] a;
    logic [DATA_W-1:0] b;
    logic [DATA_W-1:0] y;
  } dp_state_t;
  dp_state_t st_reg, st_next;

  logic [CHUNK_W-1:0] chunk_y [2];
  logic [DATA_W-1:0] shift_y, calc_y;
  logic is_shift, misaligned, load_valid, load_stall, accept;
  logic [SIZE_W-1:0] load_bytes;

  function automatic logic shift_op(input op_t op);
    shift_op = (op == op_byte_shift_left) || (op == op_byte_shift_right);
  endfunction

  function automatic logic [DATA_W-1:0] byte_shift(input op_t op, input logic [DATA_W-1:0] v,
                                                   input logic [IMM_W-1:0] imm);
    logic [SHIFT_SEL_W+2:0] amt;
    amt = {imm[SHIFT_SEL_W-1:0], 3'h0};
    if (imm > SHIFT_MAX)
      byte_shift = '0;
    else if (op == op_byte_shift_left)
      byte_shift = v << amt;
    else
      byte_shift = v >> amt;
  endfunction

  genvar c;
  for (c = 0; c < 2; c++)
  begin : g_chunk
    // Each chunk is a separate unit, so no carry or flag crosses chunks
    simd_chunk_alu u_alu (
      .op_i(op_i),
      .a_i(dst_i[c*CHUNK_W +: CHUNK_W]),
      .b_i(src_i[c*CHUNK_W +: CHUNK_W]),
      .y_o(chunk_y[c])
    );
  end

  assign is_shift = shift_op(op_i);
  assign shift_y = byte_shift(op_i, dst_i, imm_i);
  // Outside byte shifts, the 64-bit form leaves the upper chunk at zero
  assign calc_y = is_shift ? shift_y :
                  {wide_i ? chunk_y[1] : {CHUNK_W{1'b0}}, chunk_y[0]};

  assign misaligned = src_is_mem_i && wide_i && !is_shift &&
                      (mem_addr_i[ALIGN_LSB-1:0] != ALIGN_ZERO);
  assign load_bytes = wide_i ? BYTES_128 : BYTES_64;
  assign load_valid = issue_valid_i && src_is_mem_i && !is_shift && !misaligned;

  simd_store_hazard #(
    .DEPTH(STORE_DEPTH)
  ) u_hazard (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .store_valid_i(store_valid_i),
    .store_addr_i(store_addr_i),
    .store_bytes_i(store_bytes_i),
    .store_ready_o(store_ready_o),
    .store_drain_i(store_drain_i),
    .load_valid_i(load_valid),
    .load_addr_i(mem_addr_i),
    .load_bytes_i(load_bytes),
    .stall_o(load_stall)
  );

  assign issue_ready_o = !load_stall;
  assign accept = issue_valid_i && issue_ready_o;

  always_comb
  begin
    st_next = st_reg;
    st_next.valid = 1'b0;
    st_next.fault = 1'b0;
    if (accept)
    begin
      st_next.op = op_i;
      st_next.wide = wide_i;
      st_next.imm = imm_i;
      st_next.a = dst_i;
      st_next.b = src_i;
      if (misaligned)
        st_next.fault = 1'b1;
      else
      begin
        st_next.valid = 1'b1;
        st_next.y = calc_y;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign result_valid_o = st_reg.valid;
  assign result_o = st_reg.y;
  assign fault_o = st_reg.fault;

  // Checks on the registered result against the captured operands
  function automatic logic max_ok(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b,
                                  input logic [DATA_W-1:0] y, input logic is_max);
    max_ok = 1'b1;
    for (int k = 0; k < CHUNK_W / BYTE_W; k++)
    begin
      if (is_max)
        max_ok &= (y[k*BYTE_W +: BYTE_W] >= a[k*BYTE_W +: BYTE_W]) &&
                  (y[k*BYTE_W +: BYTE_W] >= b[k*BYTE_W +: BYTE_W]);
      else
        max_ok &= (y[k*BYTE_W +: BYTE_W] <= a[k*BYTE_W +: BYTE_W]) &&
                  (y[k*BYTE_W +: BYTE_W] <= b[k*BYTE_W +: BYTE_W]);
    end
  endfunction

  logic [DWORD_W-1:0] ref_mulhu, ref_madd;
  logic signed [DWORD_W-1:0] ref_p0, ref_p1;
  logic [BYTE_W:0] ref_avg;
  assign ref_mulhu = {{WORD_W{1'b0}}, st_reg.a[WORD_W-1:0]} *
                     {{WORD_W{1'b0}}, st_reg.b[WORD_W-1:0]};
  // Products formed at full width before the pair is added
  assign ref_p0 = $signed(st_reg.a[WORD_W-1:0]) * $signed(st_reg.b[WORD_W-1:0]);
  assign ref_p1 = $signed(st_reg.a[2*WORD_W-1:WORD_W]) *
                  $signed(st_reg.b[2*WORD_W-1:WORD_W]);
  assign ref_madd = ref_p0 + ref_p1;
  assign ref_avg = {1'b0, st_reg.a[BYTE_W-1:0]} + {1'b0, st_reg.b[BYTE_W-1:0]} + 9'h001;

  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  sequence done_as(op_t op);
    result_valid_o && st_reg.op == op;
  endsequence
  sequence misaligned_issue;
    accept && misaligned;
  endsequence

  chk_max_lanes: assert property (done_as(op_max_ubyte) |->
    max_ok(st_reg.a, st_reg.b, result_o, 1'b1))
    else $error("byte max below an operand");
  chk_min_lanes: assert property (done_as(op_min_ubyte) |->
    max_ok(st_reg.a, st_reg.b, result_o, 1'b0))
    else $error("byte min above an operand");
  chk_mulh_upper: assert property (done_as(op_mul_high_unsigned) |->
    result_o[WORD_W-1:0] == ref_mulhu[DWORD_W-1:WORD_W])
    else $error("multiply high lane wrong");
  chk_mulh_signed: assert property (done_as(op_mul_high_signed) |->
    result_o[WORD_W-1:0] == ref_p0[DWORD_W-1:WORD_W])
    else $error("signed multiply high lane wrong");
  chk_sad_upper_zero: assert property (done_as(op_abs_diff_sum) |->
    result_o[CHUNK_W-1:WORD_W] == '0)
    else $error("difference sum upper words not zero");
  chk_sad_equal_zero: assert property (done_as(op_abs_diff_sum) ##0
    (st_reg.a[CHUNK_W-1:0] == st_reg.b[CHUNK_W-1:0]) |-> result_o[WORD_W-1:0] == '0)
    else $error("difference sum of equal operands not zero");
  chk_avg_round: assert property (done_as(op_average_byte) |->
    result_o[BYTE_W-1:0] == ref_avg[BYTE_W:1])
    else $error("byte average wrong");
  chk_madd_pair: assert property (done_as(op_word_multiply_add) |->
    result_o[DWORD_W-1:0] == ref_madd)
    else $error("multiply add low dword wrong");
  chk_dword_mul: assert property (done_as(op_low_dword_unsigned_multiply) |->
    result_o[CHUNK_W-1:0] == {{DWORD_W{1'b0}}, st_reg.a[DWORD_W-1:0]} *
                             {{DWORD_W{1'b0}}, st_reg.b[DWORD_W-1:0]})
    else $error("low dword product wrong");
  chk_dword_mul_wide: assert property (done_as(op_low_dword_unsigned_multiply) ##0
    st_reg.wide |-> result_o[DATA_W-1:CHUNK_W] ==
    {{DWORD_W{1'b0}}, st_reg.a[CHUNK_W+DWORD_W-1:CHUNK_W]} *
    {{DWORD_W{1'b0}}, st_reg.b[CHUNK_W+DWORD_W-1:CHUNK_W]})
    else $error("upper low dword product wrong");
  chk_qadd_wrap: assert property (done_as(op_quadword_add) ##0 st_reg.wide |->
    result_o[DATA_W-1:CHUNK_W] == st_reg.a[DATA_W-1:CHUNK_W] + st_reg.b[DATA_W-1:CHUNK_W])
    else $error("upper quadword sum wrong");
  chk_qsub_wrap: assert property (done_as(op_quadword_subtract) |->
    result_o[CHUNK_W-1:0] == st_reg.a[CHUNK_W-1:0] - st_reg.b[CHUNK_W-1:0])
    else $error("quadword difference wrong");
  chk_narrow_upper: assert property (result_valid_o && !st_reg.wide &&
    !shift_op(st_reg.op) |-> result_o[DATA_W-1:CHUNK_W] == '0)
    else $error("64-bit form touched upper chunk");
  chk_shift_clear: assert property (result_valid_o && shift_op(st_reg.op) &&
    st_reg.imm > SHIFT_MAX |-> result_o == '0)
    else $error("oversized byte shift not cleared");
  chk_shift_fill: assert property (result_valid_o && shift_op(st_reg.op) &&
    st_reg.imm != '0 && st_reg.imm <= SHIFT_MAX |-> ((st_reg.op == op_byte_shift_left) ?
    result_o[BYTE_W-1:0] == '0 : result_o[DATA_W-1:DATA_W-BYTE_W] == '0))
    else $error("byte shift did not zero fill");
  chk_fault_raise: assert property (misaligned_issue |=> fault_o && !result_valid_o)
    else $error("unaligned operand without fault");
  chk_stall_hold: assert property (issue_valid_i && !issue_ready_o |=>
    !result_valid_o && !fault_o)
    else $error("stalled issue produced output");
endmodule // simd_datapath
`default_nettype wire

// ==== simd_pkg.sv ====
// Constants, opcodes and widths shared by the packed integer datapath
// Assumes a single core clock and an issue stage that holds requests while stalled
package simd_pkg;
  localparam int DATA_W = 128;
  localparam int CHUNK_W = 64;
  localparam int DWORD_W = 32;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 32;
  localparam int SIZE_W = 5;
  localparam int IMM_W = 8;
  localparam int ALIGN_LSB = 4;
  localparam int SHIFT_SEL_W = 4;
  localparam logic [IMM_W-1:0] SHIFT_MAX = 8'h0f;
  localparam logic [SIZE_W-1:0] BYTES_64 = 5'h08;
  localparam logic [SIZE_W-1:0] BYTES_128 = 5'h10;
  localparam logic AVG_CARRY_IN = 1'b1;
  localparam logic [ALIGN_LSB-1:0] ALIGN_ZERO = 4'h0;

  typedef enum logic [3:0] {
    op_max_ubyte,
    op_min_ubyte,
    op_mul_high_unsigned,
    op_mul_high_signed,
    op_abs_diff_sum,
    op_average_byte,
    op_average_word,
    op_word_multiply_add,
    op_low_dword_unsigned_multiply,
    op_quadword_add,
    op_quadword_subtract,
    op_byte_shift_left,
    op_byte_shift_right
  } op_t;
endpackage

// ==== simd_chunk_alu.sv ====
// One 64-bit chunk of the packed integer datapath, purely combinational
// Assumes the caller selects the chunk result and handles byte shifts
`timescale 1ns/100ps
`default_nettype none
module simd_chunk_alu (
  input wire simd_pkg::op_t op_i,
  input wire logic [simd_pkg::CHUNK_W-1:0] a_i,
  input wire logic [simd_pkg::CHUNK_W-1:0] b_i,
  output logic [simd_pkg::CHUNK_W-1:0] y_o
);
  import simd_pkg::*;
  localparam int NB = CHUNK_W / BYTE_W;
  localparam int NW = CHUNK_W / WORD_W;
  logic [CHUNK_W-1:0] y_max, y_min, y_avgb, y_avgw, y_mulhu, y_mulh, y_madd;
  logic [BYTE_W-1:0] diff [NB];
  logic signed [DWORD_W-1:0] prod [NW];
  logic [WORD_W-1:0] sad_sum;
  genvar i;
  for (i = 0; i < NB; i++)
  begin : g_byte
    logic [BYTE_W-1:0] ba, bb;
    logic [BYTE_W:0] bsum;
    assign ba = a_i[i*BYTE_W +: BYTE_W];
    assign bb = b_i[i*BYTE_W +: BYTE_W];
    assign y_max[i*BYTE_W +: BYTE_W] = (ba > bb) ? ba : bb;
    assign y_min[i*BYTE_W +: BYTE_W] = (ba < bb) ? ba : bb;
    assign bsum = {1'b0, ba} + {1'b0, bb} + {{BYTE_W{1'b0}}, AVG_CARRY_IN};
    assign y_avgb[i*BYTE_W +: BYTE_W] = bsum[BYTE_W:1];
    assign diff[i] = (ba > bb) ? ba - bb : bb - ba;
  end
  for (i = 0; i < NW; i++)
  begin : g_word
    logic [WORD_W-1:0] wa, wb;
    logic [DWORD_W-1:0] pu;
    logic [WORD_W:0] wsum;
    assign wa = a_i[i*WORD_W +: WORD_W];
    assign wb = b_i[i*WORD_W +: WORD_W];
    assign pu = {{WORD_W{1'b0}}, wa} * {{WORD_W{1'b0}}, wb};
    assign prod[i] = $signed(wa) * $signed(wb);
    assign y_mulhu[i*WORD_W +: WORD_W] = pu[DWORD_W-1:WORD_W];
    assign y_mulh[i*WORD_W +: WORD_W] = prod[i][DWORD_W-1:WORD_W];
    assign wsum = {1'b0, wa} + {1'b0, wb} + {{WORD_W{1'b0}}, AVG_CARRY_IN};
    assign y_avgw[i*WORD_W +: WORD_W] = wsum[WORD_W:1];
  end
  for (i = 0; i < NW / 2; i++)
  begin : g_madd
    assign y_madd[i*DWORD_W +: DWORD_W] = DWORD_W'(prod[2*i] + prod[2*i+1]);
  end
  always_comb
  begin
    sad_sum = '0;
    for (int k = 0; k < NB; k++)
    begin
      sad_sum = sad_sum + WORD_W'(diff[k]);
    end
  end
  always_comb
  begin
    case (op_i)
      op_max_ubyte: y_o = y_max;
      op_min_ubyte: y_o = y_min;
      op_mul_high_unsigned: y_o = y_mulhu;
      op_mul_high_signed: y_o = y_mulh;
      op_abs_diff_sum: y_o = {{(CHUNK_W-WORD_W){1'b0}}, sad_sum};
      op_average_byte: y_o = y_avgb;
      op_average_word: y_o = y_avgw;
      op_word_multiply_add: y_o = y_madd;
      op_low_dword_unsigned_multiply:
        y_o = {{DWORD_W{1'b0}}, a_i[DWORD_W-1:0]} * {{DWORD_W{1'b0}}, b_i[DWORD_W-1:0]};
      op_quadword_add: y_o = a_i + b_i;
      op_quadword_subtract: y_o = a_i - b_i;
      default: y_o = '0;
    endcase
  end
endmodule // simd_chunk_alu
`default_nettype wire

// ==== simd_store_hazard.sv ====
// Pending store tracker deciding whether a load must wait for stores to drain
// Assumes drain pulses retire the oldest pending store, in program order
`timescale 1ns/100ps
`default_nettype none
module simd_store_hazard #(
  parameter int DEPTH = 4
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic store_valid_i,
  input wire logic [simd_pkg::ADDR_W-1:0] store_addr_i,
  input wire logic [simd_pkg::SIZE_W-1:0] store_bytes_i,
  output logic store_ready_o,
  input wire logic store_drain_i,
  input wire logic load_valid_i,
  input wire logic [simd_pkg::ADDR_W-1:0] load_addr_i,
  input wire logic [simd_pkg::SIZE_W-1:0] load_bytes_i,
  output logic stall_o
);
  import simd_pkg::*;
  localparam int CNT_W = $clog2(DEPTH + 1);
  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic [DEPTH-1:0][ADDR_W-1:0] addr;
    logic [DEPTH-1:0][SIZE_W-1:0] size;
  } hz_state_t;
  hz_state_t st_reg, st_next;
  logic [CNT_W-1:0] hits;
  logic covered;

  function automatic logic overlaps(input logic [ADDR_W-1:0] a0, input logic [SIZE_W-1:0] s0,
                                    input logic [ADDR_W-1:0] a1, input logic [SIZE_W-1:0] s1);
    overlaps = ({1'b0, a0} < {1'b0, a1} + (ADDR_W+1)'(s1)) &&
               ({1'b0, a1} < {1'b0, a0} + (ADDR_W+1)'(s0));
  endfunction

  assign store_ready_o = (st_reg.count != CNT_W'(DEPTH));
  always_comb
  begin
    hits = '0;
    covered = 1'b0;
    for (int k = 0; k < DEPTH; k++)
    begin
      if (CNT_W'(k) < st_reg.count &&
          overlaps(st_reg.addr[k], st_reg.size[k], load_addr_i, load_bytes_i))
      begin
        hits = hits + 1'b1;
        covered = covered |
                  ((st_reg.addr[k] == load_addr_i) && (st_reg.size[k] >= load_bytes_i));
      end
    end
  end
  // Forwarding only from one store that starts at the load and covers it
  assign stall_o = load_valid_i && (hits != '0) &&
                   !((hits == CNT_W'(1)) && covered);

  always_comb
  begin
    st_next = st_reg;
    if (store_drain_i && st_reg.count != '0)
    begin
      for (int k = 0; k < DEPTH - 1; k++)
      begin
        st_next.addr[k] = st_reg.addr[k+1];
        st_next.size[k] = st_reg.size[k+1];
      end
      st_next.count = st_reg.count - 1'b1;
    end
    if (store_valid_i && store_ready_o)
    begin
      st_next.addr[st_next.count] = store_addr_i;
      st_next.size[st_next.count] = store_bytes_i;
      st_next.count = st_next.count + 1'b1;
    end
  end
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  // Checked straight from the queue entries, not from the hit counter
  sequence two_pending_overlapped;
    load_valid_i && st_reg.count == CNT_W'(2) &&
    overlaps(st_reg.addr[0], st_reg.size[0], load_addr_i, load_bytes_i) &&
    overlaps(st_reg.addr[1], st_reg.size[1], load_addr_i, load_bytes_i);
  endsequence
  chk_multi_store_stall: assert property (two_pending_overlapped |-> stall_o)
    else $error("load over several stores not stalled");
  chk_offset_load_stall: assert property (load_valid_i && st_reg.count == CNT_W'(1) &&
    overlaps(st_reg.addr[0], st_reg.size[0], load_addr_i, load_bytes_i) &&
    st_reg.addr[0] != load_addr_i |-> stall_o)
    else $error("misaligned load after store not stalled");
  chk_idle_no_stall: assert property (!load_valid_i || st_reg.count == '0 |-> !stall_o)
    else $error("stall without load or pending store");
endmodule // simd_store_hazard
`default_nettype wire

// ==== store_drain_model.sv ====
// Partner model: memory side that retires stores held pending by the datapath
// Assumes a store is taken on an edge where store_valid_i and store_ready_i are high
`timescale 1ns/100ps
`default_nettype none
module store_drain_model (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic hold_i,
  input wire logic store_valid_i,
  input wire logic store_ready_i,
  output logic store_drain_o
);
  logic [3:0] pending_reg;

  // Retires one store every other cycle, none while held back
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pending_reg <= 4'h0;
      store_drain_o <= 1'b0;
    end
    else
    begin
      pending_reg <= pending_reg + {3'h0, store_valid_i & store_ready_i} - {3'h0, store_drain_o};
      store_drain_o <= !hold_i && (pending_reg != 4'h0) && !store_drain_o;
    end
  end
endmodule // store_drain_model
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the packed integer datapath
// Assumes the store drain partner model and the datapath package
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import simd_pkg::*;
  typedef struct packed {logic fault; logic [127:0] val;} exp_t;
  logic clock_i = 1'b0;
  logic rstn_i = 1'b0;
  logic issue_valid = 1'b0;
  op_t op = op_max_ubyte;
  logic wide = 1'b0;
  logic [127:0] dst = 128'h0;
  logic [127:0] src = 128'h0;
  logic src_is_mem = 1'b0;
  logic [31:0] mem_addr = 32'h0;
  logic [7:0] imm = 8'h0;
  logic store_valid = 1'b0;
  logic [31:0] store_addr = 32'h0;
  logic [4:0] store_bytes = 5'h4;
  logic hold = 1'b0;
  logic issue_ready, store_ready, store_drain, result_valid, fault;
  logic [127:0] result, last_res, d, s;
  logic [31:0] seed = 32'h00000047;
  logic [7:0] im;
  exp_t exp_q[$];
  exp_t mon_e;
  int failures = 0;
  int n_tests = 0;

  simd_datapath #(.STORE_DEPTH(4)) i_dut (.clock_i(clock_i), .rstn_i(rstn_i),
    .issue_valid_i(issue_valid), .issue_ready_o(issue_ready), .op_i(op), .wide_i(wide),
    .dst_i(dst), .src_i(src), .src_is_mem_i(src_is_mem), .mem_addr_i(mem_addr),
    .imm_i(imm), .store_valid_i(store_valid), .store_addr_i(store_addr),
    .store_bytes_i(store_bytes), .store_ready_o(store_ready), .store_drain_i(store_drain),
    .result_valid_o(result_valid), .result_o(result), .fault_o(fault));

  store_drain_model i_drain (.clock_i(clock_i), .rstn_i(rstn_i), .hold_i(hold),
    .store_valid_i(store_valid), .store_ready_i(store_ready), .store_drain_o(store_drain));

  initial
  begin
    forever #10 clock_i = ~clock_i;
  end

  function automatic logic [31:0] rnd32();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected 64-bit chunk, destination first, source second
  function automatic logic [63:0] ref_chunk(op_t o, logic [63:0] a, logic [63:0] b);
    logic [63:0] y;
    logic [31:0] p;
    logic [16:0] t;
    logic [15:0] sum;
    y = 64'h0;
    sum = 16'h0;
    case (o)
      op_max_ubyte:
        for (int k = 0; k < 8; k++)
          y[8*k+:8] = (a[8*k+:8] > b[8*k+:8]) ? a[8*k+:8] : b[8*k+:8];
      op_min_ubyte:
        for (int k = 0; k < 8; k++)
          y[8*k+:8] = (a[8*k+:8] < b[8*k+:8]) ? a[8*k+:8] : b[8*k+:8];
      op_mul_high_unsigned, op_mul_high_signed:
        for (int k = 0; k < 4; k++)
        begin
          if (o == op_mul_high_signed)
            p = $signed(a[16*k+:16]) * $signed(b[16*k+:16]);
          else
            p = a[16*k+:16] * b[16*k+:16];
          y[16*k+:16] = p[31:16];
        end
      op_abs_diff_sum:
      begin
        for (int k = 0; k < 8; k++)
          sum = sum + ((a[8*k+:8] > b[8*k+:8]) ? a[8*k+:8] - b[8*k+:8] : b[8*k+:8] - a[8*k+:8]);
        y[15:0] = sum;
      end
      op_average_byte:
        for (int k = 0; k < 8; k++)
        begin
          t = {9'h0, a[8*k+:8]} + {9'h0, b[8*k+:8]} + 17'h1;
          y[8*k+:8] = t[8:1];
        end
      op_average_word:
        for (int k = 0; k < 4; k++)
        begin
          t = {1'b0, a[16*k+:16]} + {1'b0, b[16*k+:16]} + 17'h1;
          y[16*k+:16] = t[16:1];
        end
      op_word_multiply_add:
        for (int k = 0; k < 2; k++)
        begin
          p = $signed(a[32*k+:16]) * $signed(b[32*k+:16])
            + $signed(a[32*k+16+:16]) * $signed(b[32*k+16+:16]);
          y[32*k+:32] = p;
        end
      op_low_dword_unsigned_multiply: y = a[31:0] * b[31:0];
      op_quadword_add: y = a + b;
      op_quadword_subtract: y = a - b;
      default: y = 64'h0;
    endcase
    return y;
  endfunction

  function automatic logic [127:0] ref128(op_t o, logic w, logic [127:0] a, logic [127:0] b,
                                          logic [7:0] n);
    if (o == op_byte_shift_left)
      return (n > 8'h0f) ? 128'h0 : a << (8 * n);
    if (o == op_byte_shift_right)
      return (n > 8'h0f) ? 128'h0 : a >> (8 * n);
    return {w ? ref_chunk(o, a[127:64], b[127:64]) : 64'h0, ref_chunk(o, a[63:0], b[63:0])};
  endfunction

  task automatic check(input string name, input logic [127:0] seen, input logic [127:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Presents one request, holds it until taken, notes the expected answer
  task automatic issue(input op_t o, input logic w, input logic [127:0] a, input logic [127:0] b,
                       input logic m, input logic [31:0] ad, input logic [7:0] n, input logic stl);
    int cnt;
    exp_t e;
    cnt = 0;
    e.fault = m && w && ad[3:0] != 4'h0 && o != op_byte_shift_left && o != op_byte_shift_right;
    e.val = e.fault ? last_res : ref128(o, w, a, b, n);
    issue_valid <= 1'b1;
    op <= o;
    wide <= w;
    dst <= a;
    src <= b;
    src_is_mem <= m;
    mem_addr <= ad;
    imm <= n;
    @(posedge clock_i);
    while (issue_ready !== 1'b1 && cnt < 300)
    begin
      cnt++;
      if (cnt == 6)
        hold <= 1'b0;
      @(posedge clock_i);
    end
    if (cnt == 300)
      failures++;
    exp_q.push_back(e);
    if (!e.fault)
      last_res = e.val;
    check("stall", {127'h0, cnt != 0}, {127'h0, stl});
  endtask

  task automatic store(input logic [31:0] ad, input logic [4:0] nb);
    int cnt;
    cnt = 0;
    @(posedge clock_i);
    store_valid <= 1'b1;
    store_addr <= ad;
    store_bytes <= nb;
    @(posedge clock_i);
    while (store_ready !== 1'b1 && cnt < 300)
    begin
      cnt++;
      @(posedge clock_i);
    end
    if (cnt == 300)
      failures++;
    store_valid <= 1'b0;
  endtask

  task automatic wrap_up();
    if (failures == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge clock_i)
  begin
    if (result_valid === 1'b1 || fault === 1'b1)
    begin
      mon_e = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
      check("fault", {127'h0, fault}, {127'h0, mon_e.fault});
      check("valid", {127'h0, result_valid}, {127'h0, !mon_e.fault});
      check("result", result, mon_e.val);
    end
  end

  initial
  begin
    repeat (5000) @(posedge clock_i);
    failures++;
    wrap_up();
  end

  initial
  begin
    last_res = 128'h0;
    repeat (12) @(posedge clock_i);
    rstn_i <= 1'b1;
    @(posedge clock_i);
    check("reset result", result, 128'h0);
    check("reset flags", {126'h0, result_valid, fault}, 128'h0);
    check("reset ready", {126'h0, issue_ready, store_ready}, 128'h3);
    // All opcodes back to back, both widths, register and memory source
    for (int r = 0; r < 6; r++)
      for (int i = 0; i < 13; i++)
      begin
        d = (r < 2) ? '1 : (r == 2) ? {8{16'h8000}} : {rnd32(), rnd32(), rnd32(), rnd32()};
        s = (r == 0) ? '1 : (r == 1) ? {2{64'h1}} : (r == 2) ? {8{16'h8000}} : {rnd32(),
            rnd32(), rnd32(), rnd32()};
        im = (r == 0) ? 8'h0f : (r == 1) ? 8'h10 : (r == 2) ? 8'hff : 8'(rnd32() % 20);
        issue(op_t'(i), r[0], d, s, r[1], 32'h200, im, 1'b0);
      end
    // Alignment fault only for wide non-shift memory operands
    issue(op_quadword_add, 1'b1, d, s, 1'b1, 32'h104, 8'h0, 1'b0);
    issue(op_quadword_subtract, 1'b1, s, d, 1'b1, 32'h100, 8'h0, 1'b0);
    issue(op_byte_shift_left, 1'b1, d, s, 1'b1, 32'h104, 8'h3, 1'b0);
    issue(op_low_dword_unsigned_multiply, 1'b0, d, s, 1'b1, 32'h104, 8'h0, 1'b0);
    issue_valid <= 1'b0;
    // 64-bit load over two 4-byte stores waits for both to drain
    hold <= 1'b1;
    store(32'h1000, 5'h4);
    store(32'h1004, 5'h4);
    issue(op_max_ubyte, 1'b0, d, s, 1'b1, 32'h1000, 8'h0, 1'b1);
    issue_valid <= 1'b0;
    repeat (8) @(posedge clock_i);
    // Aligned narrow load after a wide store passes, misaligned one waits
    hold <= 1'b1;
    store(32'h2000, 5'h10);
    issue(op_min_ubyte, 1'b0, d, s, 1'b1, 32'h2000, 8'h0, 1'b0);
    issue(op_min_ubyte, 1'b0, s, d, 1'b1, 32'h3000, 8'h0, 1'b0);
    issue(op_average_word, 1'b0, d, s, 1'b1, 32'h2004, 8'h0, 1'b1);
    issue_valid <= 1'b0;
    repeat (8) @(posedge clock_i);
    check("left over", {96'h0, 32'(exp_q.size())}, 128'h0);
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
